// ### uos_otg_status.sv
// Notes on behaviour
// [RULE_01] Cable identity bit 7 reads 1 for no cable or B cable, 0 for A.
// [RULE_02] Line-state-stable reads 1 only after 1 ms of unchanged SE0 and J.
// [RULE_03] Stability watches SE0 at control bit 6 and J at control bit 7.
// [RULE_04] Session-valid bit 3 is 1 while bus voltage is above session valid.
// [RULE_05] Session-end bit 2 is 1 when voltage is below session valid on B.
// [RULE_06] Bus-valid bit 0 is 1 when voltage is above session valid on A.
// [RULE_07] Status bits 31-8, 6, 4, 1 read zero; whole register read-only.
// [RULE_08] Registers have clear, set, flip aliases at plus 0x4, 0x8, 0xC; event status and event mask decode their base address only.
// [RULE_09] Error flag register has only the clear alias.
// [RULE_10] Transfer status register has no aliases; base address only.
// [RULE_11] Error interrupt while any error flag and its enable are both set.
// [RULE_12] Alias write of ones clears, sets or flips just those bits.
//
// The address-and-strobe port was chosen for this implementation.
`include "uos_map.svh"
`default_nettype none

module uos_otg_status
  import uos_pkg::*;
#(
  parameter int unsigned LINE_STABLE_CYCLES = `UOS_LINE_STABLE_TIME_NS / `UOS_CLK_PERIOD_NS
)
(
  input  wire logic      clk,            // 200 MHz clock
  input  wire logic      reset_n,        // Synchronous reset, active low
  input  wire uos_addr_t regAddr,        // Register byte address
  input  wire uos_word_t regWrData,      // Write data
  input  wire logic      regWrEn,        // Write strobe
  input  wire logic      regRdEn,        // Read strobe
  output logic           [31:0] regRdData, // Read data, cycle after strobe
  input  wire logic      cableIdLevel,   // Identity pin, 1 = no cable or B
  input  wire logic      vbusAboveSess,  // Bus voltage above session valid
  input  wire logic      lineSe0,        // Single-ended zero seen
  input  wire logic      lineJLevel,     // J state seen
  input  wire uos_byte_t errorEvent,     // One-cycle error pulses
  input  wire logic [3:0] xferEndpoint,  // Last transfer endpoint
  input  wire logic      xferDirection,  // Last transfer direction
  input  wire logic      pingPongIndex,  // Last transfer ping-pong bank
  output uos_byte_t      controlOut,     // Control register image
  output uos_byte_t      deviceAddress,  // Device address register
  output logic           errorIrq,       // Error interrupt request
  output logic           irq             // Level interrupt
);

  // Address decode
  uos_addr_t baseAddr;
  uos_sub_t  subSel;
  logic      hitIrqEn;
  logic      hitErrFlags;
  logic      hitErrEn;
  logic      hitXfer;
  logic      hitCtl;
  logic      hitAddr;
  logic      hitDesc;
  logic      hitOtg;
  logic      hitEvtSts;
  logic      hitEvtMask;

  assign baseAddr    = {regAddr[15:4], 4'h0};
  assign subSel      = regAddr[3:2];
  assign hitIrqEn    = (baseAddr == `UOS_OFS_IRQ_ENABLE);   // [RULE_08]
  assign hitErrFlags = (baseAddr == `UOS_OFS_ERROR_FLAGS);
  assign hitErrEn    = (baseAddr == `UOS_OFS_ERROR_ENABLE);
  assign hitCtl      = (baseAddr == `UOS_OFS_CONTROL);
  assign hitAddr     = (baseAddr == `UOS_OFS_DEV_ADDRESS);
  assign hitDesc     = (baseAddr == `UOS_OFS_DESC_PTR_LOW);
  assign hitEvtSts   = (regAddr == `UOS_OFS_EVENT_STATUS);
  assign hitEvtMask  = (regAddr == `UOS_OFS_EVENT_MASK);
  assign hitXfer     = (regAddr == `UOS_OFS_XFER_STATUS);    // [RULE_10]
  assign hitOtg      = (regAddr == `UOS_OFS_OTG_STATUS);

  // Alias write of ones: base stores, others clear, set or flip
  function automatic uos_byte_t aliasApply(input uos_byte_t cur, input uos_byte_t wd, input uos_sub_t sub);
    uos_byte_t res;
    res = cur;
    case (sub)
      `UOS_SUB_BASE:  res = wd;
      `UOS_SUB_CLEAR: res = cur & ~wd;   // [RULE_12]
      `UOS_SUB_SET:   res = cur | wd;    // [RULE_12]
      `UOS_SUB_FLIP:  res = cur ^ wd;    // [RULE_12]
      default:        res = cur;
    endcase
    return res;
  endfunction : aliasApply

  // Registers
  uos_byte_t irqEnable_q;
  uos_byte_t irqEnable_d;
  uos_byte_t errFlags_q;
  uos_byte_t errFlags_d;
  uos_byte_t errEnable_q;
  uos_byte_t errEnable_d;
  uos_byte_t ctlBits_q;
  uos_byte_t ctlBits_d;
  uos_byte_t devAddr_q;
  uos_byte_t devAddr_d;
  uos_byte_t descPtr_q;
  uos_byte_t descPtr_d;
  uos_byte_t evtStatus_q;
  uos_byte_t evtStatus_d;
  uos_byte_t evtMask_q;
  uos_byte_t evtMask_d;
  uos_byte_t wrByte;

  assign wrByte = regWrData[7:0];

  assign irqEnable_d = (regWrEn && hitIrqEn) ? aliasApply(irqEnable_q, wrByte, subSel) : irqEnable_q;
  assign errEnable_d = (regWrEn && hitErrEn) ? aliasApply(errEnable_q, wrByte, subSel) : errEnable_q;
  assign devAddr_d   = (regWrEn && hitAddr) ? aliasApply(devAddr_q, wrByte, subSel) : devAddr_q;
  assign descPtr_d   = (regWrEn && hitDesc)
                       ? (aliasApply(descPtr_q, wrByte, subSel) & `UOS_DESC_PTR_MASK)
                       : descPtr_q;
  // Line bits in control are hardware-owned, so aliases touch only the low six
  assign ctlBits_d   = (regWrEn && hitCtl)
                       ? (aliasApply(ctlBits_q, wrByte, subSel) & `UOS_CTL_WR_MASK)
                       : ctlBits_q;

  // Error flags: base write of ones clears, clear alias clears, set and flip
  // aliases do nothing; a new error in the same cycle still lands
  logic errClearHit;
  assign errClearHit = regWrEn && hitErrFlags
                       && ((subSel == `UOS_SUB_BASE) || (subSel == `UOS_SUB_CLEAR)); // [RULE_09]
  assign errFlags_d  = (errClearHit ? (errFlags_q & ~wrByte) : errFlags_q) | errorEvent;

  // Line state tracking
  logic [1:0]  lineNow_q;
  logic [1:0]  lineIn;
  logic        lineChanged;
  logic [31:0] lineHold_q;
  logic [31:0] lineHold_d;
  logic        lineStable;
  logic        lineStable_q;

  assign lineIn      = {lineJLevel, lineSe0};
  assign lineChanged = (lineIn != lineNow_q);                             // [RULE_03]
  assign lineStable  = !lineChanged && (lineHold_q >= LINE_STABLE_CYCLES); // [RULE_02]
  always_comb
  begin
    if (lineChanged)
    begin
      lineHold_d = 32'h0;                                                  // [RULE_02]
    end
    else if (lineHold_q < LINE_STABLE_CYCLES)
    begin
      lineHold_d = lineHold_q + 32'h1;
    end
    else
    begin
      lineHold_d = lineHold_q;
    end
  end

  // On-the-go status image
  uos_byte_t otgStatus;
  uos_byte_t otgStatus_q;
  logic      aDevice;

  assign aDevice = !cableIdLevel;
  always_comb
  begin
    otgStatus = 8'h00;                                                      // [RULE_07]
    otgStatus[`UOS_OTG_CABLE_ID_BIT]   = cableIdLevel;                      // [RULE_01]
    otgStatus[`UOS_OTG_LINE_STBL_BIT]  = lineStable_q;                      // [RULE_02]
    otgStatus[`UOS_OTG_SESS_VLD_BIT]   = vbusAboveSess;                     // [RULE_04]
    otgStatus[`UOS_OTG_B_SESS_END_BIT] = !aDevice && !vbusAboveSess;        // [RULE_05]
    otgStatus[`UOS_OTG_A_BUS_VLD_BIT]  = aDevice && vbusAboveSess;          // [RULE_06]
  end

  // Error request and interrupt events
  logic      errReq;
  logic      errReq_q;
  uos_byte_t evtSet;
  logic      evtClearHit;

  assign errReq = |(errFlags_q & errEnable_q);                              // [RULE_11]
  always_comb
  begin
    evtSet = 8'h00;
    evtSet[`UOS_EVT_CABLE_ID]    = otgStatus[`UOS_OTG_CABLE_ID_BIT] != otgStatus_q[`UOS_OTG_CABLE_ID_BIT];
    evtSet[`UOS_EVT_LINE_STABLE] = lineStable && !lineStable_q;
    evtSet[`UOS_EVT_SESSION]     = otgStatus[`UOS_OTG_SESS_VLD_BIT] != otgStatus_q[`UOS_OTG_SESS_VLD_BIT];
    evtSet[`UOS_EVT_ERROR]       = errReq && !errReq_q;
  end
  assign evtClearHit = regWrEn && hitEvtSts;
  // Set wins over a write-one clear in the same cycle
  assign evtStatus_d = (evtClearHit ? (evtStatus_q & ~wrByte) : evtStatus_q) | evtSet;
  assign evtMask_d   = (regWrEn && hitEvtMask) ? wrByte : evtMask_q;

  // Read mux; alias addresses and unmapped words read zero
  uos_byte_t ctlRead;
  uos_byte_t xferRead;
  uos_byte_t rdByte;
  logic      rdBase;

  assign ctlRead  = {lineNow_q[1], lineNow_q[0], ctlBits_q[5:0]};           // [RULE_03]
  assign xferRead = {xferEndpoint, xferDirection, pingPongIndex, 2'b00};
  assign rdBase   = (subSel == `UOS_SUB_BASE);
  always_comb
  begin
    rdByte = 8'h00;
    if (hitOtg)
    begin
      rdByte = otgStatus_q;                                                 // [RULE_07]
    end
    else if (hitXfer)
    begin
      rdByte = xferRead;                                                    // [RULE_10]
    end
    else if (hitEvtSts)
    begin
      rdByte = evtStatus_q;
    end
    else if (hitEvtMask)
    begin
      rdByte = evtMask_q;
    end
    else if (rdBase)
    begin
      case (1'b1)
        hitIrqEn:    rdByte = irqEnable_q;
        hitErrFlags: rdByte = errFlags_q;
        hitErrEn:    rdByte = errEnable_q;
        hitCtl:      rdByte = ctlRead;
        hitAddr:     rdByte = devAddr_q;
        hitDesc:     rdByte = descPtr_q;
        default:     rdByte = 8'h00;
      endcase
    end
    else
    begin
      rdByte = 8'h00;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      irqEnable_q  <= `UOS_RESET_VALUE;
      errFlags_q   <= `UOS_RESET_VALUE;
      errEnable_q  <= `UOS_RESET_VALUE;
      ctlBits_q    <= `UOS_RESET_VALUE;
      devAddr_q    <= `UOS_RESET_VALUE;
      descPtr_q    <= `UOS_RESET_VALUE;
      evtStatus_q  <= `UOS_RESET_VALUE;
      evtMask_q    <= `UOS_RESET_VALUE;
    end
    else
    begin
      irqEnable_q  <= irqEnable_d;
      errFlags_q   <= errFlags_d;
      errEnable_q  <= errEnable_d;
      ctlBits_q    <= ctlBits_d;
      devAddr_q    <= devAddr_d;
      descPtr_q    <= descPtr_d;
      evtStatus_q  <= evtStatus_d;
      evtMask_q    <= evtMask_d;
    end
  end

  // Status capture; resets to zero so the first cycles may log a change event
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      lineNow_q    <= 2'b00;
      lineHold_q   <= 32'h0;
      lineStable_q <= 1'b0;
      otgStatus_q  <= `UOS_RESET_VALUE;
      errReq_q     <= 1'b0;
    end
    else
    begin
      lineNow_q    <= lineIn;
      lineHold_q   <= lineHold_d;
      lineStable_q <= lineStable;
      otgStatus_q  <= otgStatus;
      errReq_q     <= errReq;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      regRdData     <= 32'h0;
      controlOut    <= `UOS_RESET_VALUE;
      deviceAddress <= `UOS_RESET_VALUE;
      errorIrq      <= 1'b0;
      irq           <= 1'b0;
    end
    else
    begin
      regRdData     <= regRdEn ? {24'h0, rdByte} : 32'h0;
      controlOut    <= ctlRead;
      deviceAddress <= devAddr_q;
      errorIrq      <= errReq;                                              // [RULE_11]
      irq           <= |(evtStatus_d & evtMask_d);
    end
  end

endmodule : uos_otg_status
`default_nettype wire

// ### uos_map.svh
`ifndef UOS_MAP_SVH
`define UOS_MAP_SVH

// Register byte addresses
`define UOS_OFS_OTG_STATUS     16'h5060
`define UOS_OFS_IRQ_ENABLE     16'h5210
`define UOS_OFS_ERROR_FLAGS    16'h5220
`define UOS_OFS_ERROR_ENABLE   16'h5230
`define UOS_OFS_XFER_STATUS    16'h5240
`define UOS_OFS_CONTROL        16'h5250
`define UOS_OFS_DEV_ADDRESS    16'h5260
`define UOS_OFS_DESC_PTR_LOW   16'h5270
`define UOS_OFS_EVENT_STATUS   16'h5280
`define UOS_OFS_EVENT_MASK     16'h5290

// Alias sub-offsets, address bits 3:2
`define UOS_SUB_BASE           2'h0
`define UOS_SUB_CLEAR          2'h1
`define UOS_SUB_SET            2'h2
`define UOS_SUB_FLIP           2'h3

// On-the-go status field positions
`define UOS_OTG_CABLE_ID_BIT   7
`define UOS_OTG_LINE_STBL_BIT  5
`define UOS_OTG_SESS_VLD_BIT   3
`define UOS_OTG_B_SESS_END_BIT 2
`define UOS_OTG_A_BUS_VLD_BIT  0

// Control field positions and writable mask
`define UOS_CTL_J_LEVEL_BIT    7
`define UOS_CTL_SE0_BIT        6
`define UOS_CTL_WR_MASK        8'h3f

// Descriptor pointer: bits 7:1 only
`define UOS_DESC_PTR_MASK      8'hfe

// Event status bits
`define UOS_EVT_CABLE_ID       0
`define UOS_EVT_LINE_STABLE    1
`define UOS_EVT_SESSION        2
`define UOS_EVT_ERROR          3

`define UOS_RESET_VALUE        8'h00

// Line state stability window
`define UOS_LINE_STABLE_TIME_NS 1000000
`define UOS_CLK_PERIOD_NS       5

`endif

// ### uos_pkg.sv
`default_nettype none
package uos_pkg;
  typedef logic [7:0]  uos_byte_t;
  typedef logic [31:0] uos_word_t;
  typedef logic [15:0] uos_addr_t;
  typedef logic [1:0]  uos_sub_t;
endpackage : uos_pkg
`default_nettype wire

// ### uos_usb_peer.sv
`default_nettype none
module uos_usb_peer
(
  input  wire logic       peerIsA,       // A plug inserted
  input  wire logic       peerVbus,      // Peer powers the bus
  input  wire logic [1:0] peerLine,      // 0 K or idle, 1 J, 2 SE0
  output logic            cableIdLevel,  // Identity pin level
  output logic            vbusAboveSess, // Comparator output
  output logic            lineSe0,       // Single-ended zero
  output logic            lineJLevel     // J state
);
  timeunit 1ns;
  timeprecision 100ps;
  // Identity pin pulled up; only an A plug grounds it
  assign cableIdLevel  = !peerIsA;
  assign vbusAboveSess = peerVbus;
  assign lineSe0       = (peerLine == 2'h2);
  assign lineJLevel    = (peerLine == 2'h1);
endmodule : uos_usb_peer
`default_nettype wire

// ### uos_otg_status_sva.sv
`include "uos_map.svh"
`default_nettype none
module uos_otg_status_sva
  import uos_pkg::*;
#(
  parameter int unsigned LINE_STABLE_CYCLES = 16
)
(
  input wire logic        clk,           // Clock
  input wire logic        reset_n,       // Sync reset
  input wire uos_addr_t   regAddr,       // Address
  input wire logic        regRdEn,       // Read strobe
  input wire logic [31:0] regRdData,     // Read data
  input wire logic        cableIdLevel,  // Identity
  input wire logic        vbusAboveSess, // Bus voltage
  input wire logic        lineSe0,       // SE0
  input wire logic        lineJLevel     // J
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] upCnt_q;
  logic [1:0] lastLine_q;
  int unsigned stableCnt_q;
  // Capture registers hold reset zeros for the first edges
  wire logic otgRd = regRdEn && (regAddr == `UOS_OFS_OTG_STATUS) && (upCnt_q == 2'h3);
  wire logic ctlRd = regRdEn && (regAddr == `UOS_OFS_CONTROL) && (upCnt_q == 2'h3);
  always_ff @(posedge clk)
  begin
    upCnt_q <= !reset_n ? 2'h0 : (upCnt_q == 2'h3 ? upCnt_q : upCnt_q + 2'h1);
    lastLine_q <= !reset_n ? 2'h0 : {lineJLevel, lineSe0};
    if (!reset_n || {lineJLevel, lineSe0} != lastLine_q)
      stableCnt_q <= 0;
    else if (stableCnt_q < LINE_STABLE_CYCLES + 8)
      stableCnt_q <= stableCnt_q + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_id; otgRd && $stable(cableIdLevel) |=> regRdData[7] == $past(cableIdLevel); endproperty
  a_id: assert property (p_id) else $error("identity bit wrong");
  property p_lsLow; otgRd && stableCnt_q + 2 < LINE_STABLE_CYCLES |=> !regRdData[5]; endproperty
  a_lsLow: assert property (p_lsLow) else $error("line stable too early");
  property p_lsHigh; otgRd && stableCnt_q > LINE_STABLE_CYCLES + 3 |=> regRdData[5]; endproperty
  a_lsHigh: assert property (p_lsHigh) else $error("line stable missing");
  property p_ctlLine; ctlRd && $stable({lineJLevel, lineSe0}) |=> regRdData[7:6] == $past({lineJLevel, lineSe0}); endproperty
  a_ctlLine: assert property (p_ctlLine) else $error("control line bits wrong");
  property p_sess; otgRd && $stable(vbusAboveSess) |=> regRdData[3] == $past(vbusAboveSess); endproperty
  a_sess: assert property (p_sess) else $error("session bit wrong");
  sequence s_otgSteady;
    otgRd && $stable(vbusAboveSess) && $stable(cableIdLevel);
  endsequence
  property p_bEnd; s_otgSteady |=> regRdData[2] == $past(cableIdLevel && !vbusAboveSess); endproperty
  a_bEnd: assert property (p_bEnd) else $error("session end bit wrong");
  property p_aBus; s_otgSteady |=> regRdData[0] == $past(!cableIdLevel && vbusAboveSess); endproperty
  a_aBus: assert property (p_aBus) else $error("bus valid bit wrong");
  property p_rsvd; otgRd |=> regRdData[31:8] == 24'h0 && !regRdData[6] && !regRdData[4] && !regRdData[1]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
  property p_alias; regRdEn && regAddr[3:2] != 2'h0 |=> regRdData == 32'h0; endproperty
  a_alias: assert property (p_alias) else $error("alias read not zero");
  property p_xfer; regRdEn && regAddr[15:4] == 12'h524 && regAddr[3:2] != 2'h0 |=> regRdData == 32'h0; endproperty
  a_xfer: assert property (p_xfer) else $error("transfer alias responded");
endmodule : uos_otg_status_sva
bind uos_otg_status uos_otg_status_sva #(.LINE_STABLE_CYCLES(LINE_STABLE_CYCLES)) u_sva (.clk(clk),
  .reset_n(reset_n), .regAddr(regAddr), .regRdEn(regRdEn), .regRdData(regRdData), .cableIdLevel(cableIdLevel),
  .vbusAboveSess(vbusAboveSess), .lineSe0(lineSe0), .lineJLevel(lineJLevel));
`default_nettype wire

// ### uos_otg_status_tb.sv
`default_nettype none
module uos_otg_status_tb
  import uos_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LSC = 16;
  logic clk = 1'b0, reset_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
  uos_addr_t regAddr = 16'h0;
  uos_word_t regWrData = 32'h0;
  uos_byte_t errorEvent = 8'h0;
  logic [3:0] xferEndpoint = 4'ha;
  logic xferDirection = 1'b1, pingPongIndex = 1'b0, peerIsA = 1'b0, peerVbus = 1'b0;
  logic [1:0] peerLine = 2'h0;
  logic [31:0] regRdData;
  uos_byte_t controlOut, deviceAddress;
  logic errorIrq, irq, cableIdLevel, vbusAboveSess, lineSe0, lineJLevel, id, vb;
  int errors = 0, comparisons = 0;
  uos_addr_t bases [5] = '{16'h5210, 16'h5230, 16'h5250, 16'h5260, 16'h5270};
  uos_byte_t masks [5] = '{8'hff, 8'hff, 8'h3f, 8'hff, 8'hfe};
  always #2.5 clk = ~clk;
  uos_usb_peer peer (.peerIsA(peerIsA), .peerVbus(peerVbus), .peerLine(peerLine), .cableIdLevel(cableIdLevel),
    .vbusAboveSess(vbusAboveSess), .lineSe0(lineSe0), .lineJLevel(lineJLevel));
  uos_otg_status #(.LINE_STABLE_CYCLES(LSC)) uut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .cableIdLevel(cableIdLevel), .vbusAboveSess(vbusAboveSess), .lineSe0(lineSe0), .lineJLevel(lineJLevel),
    .errorEvent(errorEvent), .xferEndpoint(xferEndpoint), .xferDirection(xferDirection),
    .pingPongIndex(pingPongIndex), .controlOut(controlOut), .deviceAddress(deviceAddress),
    .errorIrq(errorIrq), .irq(irq));
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task wr(input uos_addr_t a, input uos_word_t d);
    @(posedge clk);
    {regWrEn, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask : wr
  task rd(input uos_addr_t a, input uos_word_t exp);
    @(posedge clk);
    {regRdEn, regAddr} <= {1'b1, a};
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 check(regRdData, exp);
  endtask : rd
  task end_of_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (4000) @(posedge clk);
    errors++;
    end_of_test();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rd(bases[i], 32'h0);
      wr(bases[i], 32'h5a);
      wr(bases[i] + 16'h8, 32'h81);
      wr(bases[i] + 16'h4, 32'h0a);
      wr(bases[i] + 16'hc, 32'hff);
      rd(bases[i], {24'h0, 8'h2e & masks[i]});
      if (i == 3) check({24'h0, deviceAddress}, 32'h2e);
      // All ones shows which bits hold; line bits of control stay hardware-owned
      wr(bases[i], 32'hff);
      rd(bases[i], {24'h0, masks[i]});
      wr(bases[i], 32'h0);
    end
    wr(16'h5230, 32'h04);
    @(posedge clk) errorEvent <= 8'h05;
    @(posedge clk) errorEvent <= 8'h00;
    rd(16'h5220, 32'h05);
    check({31'h0, errorIrq}, 32'h1);
    wr(16'h5228, 32'hff);
    wr(16'h522c, 32'hff);
    rd(16'h5220, 32'h05);
    wr(16'h5224, 32'h04);
    rd(16'h5220, 32'h01);
    check({31'h0, errorIrq}, 32'h0);
    wr(16'h5248, 32'hff);
    rd(16'h5240, 32'ha8);
    rd(16'h5244, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) {peerIsA, peerVbus} <= 2'(i);
      repeat (3) @(posedge clk);
      {id, vb} = {!peerIsA, peerVbus};
      rd(16'h5060, {24'h0, id, 3'b010, vb, id & !vb, 1'b0, !id & vb});
    end
    wr(16'h5280, 32'hff);
    peerIsA <= 1'b0;
    repeat (3) @(posedge clk);
    rd(16'h5280, 32'h01);
    check({31'h0, irq}, 32'h0);
    wr(16'h5290, 32'h01);
    // Irq launches on the mask write edge; look after it settles
    #1 check({31'h0, irq}, 32'h1);
    wr(16'h5280, 32'h01);
    rd(16'h5280, 32'h0);
    check({31'h0, irq}, 32'h0);
    // SE0 breaks a long stable J-free period
    @(posedge clk) peerLine <= 2'h2;
    repeat (4) @(posedge clk);
    rd(16'h5060, 32'h88);
    rd(16'h5250, 32'h40);
    repeat (LSC - 12) @(posedge clk);
    rd(16'h5060, 32'h88);
    repeat (10) @(posedge clk);
    rd(16'h5060, 32'ha8);
    @(posedge clk) peerLine <= 2'h1;
    repeat (4) @(posedge clk);
    rd(16'h5250, 32'h80);
    check({24'h0, controlOut}, 32'h80);
    end_of_test();
  end
endmodule : uos_otg_status_tb
`default_nettype wire
